// ### inc/twm_defs.svh
// Summary of operation
// - Sample data on rising, change on falling
// - Device only pulls data low or releases
// - Protect input high blocks every memory write
// - Reads work whatever the protect input
// - Master changes data only while clock low
// - Data falling during clock high starts transfer
// - Data rising during clock high ends transfer
// - Writes complete at once, no busy state
// - Bytes of eight bits, acknowledge low ninth
// - Transmitter releases data on ninth clock
// - Stop before acknowledge abandons, enters standby
// - After not-acknowledge the device releases bus
// - After release master sends stop or restart
// - Eleven-bit address buffer selects one byte
// - Full address from upper and lower bytes
// - Current read joins new upper, held lower
// - Array of 2048 individually writable bytes
// - First byte: type, upper address, direction
// - Address increments per byte, wraps to zero
// - Current read uses joined address plus one, not right after address byte
// - Protect input steady from start to stop
`ifndef TWM_DEFS_SVH
`define TWM_DEFS_SVH

// Array geometry
`define TWM_ADDR_W 11
`define TWM_DATA_W 8
`define TWM_DEPTH 2048
`define TWM_HI_W 3

// Address word fields
`define TWM_TYPE_MSB 7
`define TWM_TYPE_LSB 4
`define TWM_HI_MSB 3
`define TWM_HI_LSB 1
`define TWM_RW_BIT 0
// Arbitrary device type value
`define TWM_TYPE_CODE 4'h5

// Bit slot of the acknowledge
`define TWM_ACK_SLOT 4'h8
`define TWM_LAST_BIT 4'h7

// Timing
`define TWM_CLK_PERIOD_NS 40
`define TWM_SCL_MIN_PERIOD_NS 1000
`define TWM_QTR_CYC \
   ((`TWM_SCL_MIN_PERIOD_NS + 4 * `TWM_CLK_PERIOD_NS - 1) / (4 * `TWM_CLK_PERIOD_NS))

`endif

// ### inc/twm_pkg.sv
package twm_pkg;
   // Device end states
   typedef enum logic [2:0] {TWM_D_IDLE, TWM_D_DEV, TWM_D_ADDR, TWM_D_WR, TWM_D_RD} twm_dst_e;
   // Master end states
   typedef enum logic [2:0] {TWM_H_IDLE, TWM_H_START, TWM_H_DISP, TWM_H_BIT, TWM_H_STOP} twm_hst_e;
   // Master commands
   typedef enum logic [1:0] {TWM_OP_WRITE, TWM_OP_RAND_RD, TWM_OP_CUR_RD} twm_op_e;
   // Kind of each step of a command
   typedef enum logic [1:0] {TWM_K_TX, TWM_K_RX, TWM_K_RESTART, TWM_K_STOP} twm_kind_e;
endpackage : twm_pkg

// ### inc/twm_if.sv
`timescale 1ns/1ps
interface twm_if;
   logic scl;
   logic mst_sda_oe;
   logic tgt_sda_oe;
   logic wp;
   logic sda;

   // Open-drain line with pull-up
   assign sda = ~(mst_sda_oe | tgt_sda_oe);

   modport mst (output scl, output mst_sda_oe, output wp, input sda);
   modport tgt (input scl, input sda, input wp, output tgt_sda_oe);
endinterface : twm_if

// ### rtl/twm_mem.sv
`timescale 1ns/1ps
module twm_mem #(
   parameter int unsigned DEPTH = 2048,
   parameter int unsigned AW = 11,
   parameter int unsigned DW = 8
) (
   // Clock
   input wire logic clk,
   // Write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // Read port
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] store_ff [DEPTH];

   // One byte written per strobe
   always_ff @(posedge clk) begin
      if (we) begin
         store_ff[waddr] <= wdata;
      end
   end

   assign rdata = store_ff[raddr];
endmodule : twm_mem

// ### rtl/twm_master.sv
`timescale 1ns/1ps
`include "twm_defs.svh"
module twm_master import twm_pkg::*; #(
   parameter logic [3:0] TYPE_CODE = `TWM_TYPE_CODE,
   parameter int unsigned QTR = `TWM_QTR_CYC
) (
   // Link
   twm_if.mst bus,
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Command
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire twm_op_e cmd_op,
   input wire logic [`TWM_ADDR_W-1:0] cmd_addr,
   input wire logic [`TWM_DATA_W-1:0] cmd_wdata,
   input wire logic cmd_wp,
   // Response
   output logic rsp_valid,
   output logic rsp_nack,
   output logic [`TWM_DATA_W-1:0] rsp_rdata
);
   localparam logic [7:0] QTR_M1 = 8'(QTR - 1);

   twm_hst_e st_ff, nxt_st;
   twm_op_e op_ff;
   twm_kind_e kind;
   logic [7:0] qcnt_ff;
   logic [1:0] ph_ff;
   logic [2:0] step_ff, nxt_step;
   logic [3:0] bit_ff, nxt_bit;
   logic [`TWM_ADDR_W-1:0] addr_ff;
   logic [7:0] wdata_ff, tx_byte, shift_ff, rdata_ff;
   logic wp_ff, nack_ff, rsp_valid_ff, scl_ff, oe_ff, nxt_scl, nxt_oe;
   logic sda_meta_ff, sda_s_ff;

   // Phase timing
   wire timed = (st_ff == TWM_H_START) | (st_ff == TWM_H_BIT) | (st_ff == TWM_H_STOP);
   wire tick = timed & (qcnt_ff == QTR_M1);
   wire q_end = tick & (ph_ff == 2'h3);
   wire data_bit = ~bit_ff[3];
   wire tx_bit = tx_byte[~bit_ff[2:0]];
   wire [7:0] dev_w = {TYPE_CODE, addr_ff[10:8], 1'b0};
   wire [7:0] dev_r = {TYPE_CODE, addr_ff[10:8], 1'b1};
   wire accept = (st_ff == TWM_H_IDLE) & cmd_valid;

   // Step plan of each command
   always_comb begin
      kind = TWM_K_STOP;
      tx_byte = 8'h00;
      case (op_ff)
         TWM_OP_WRITE: begin
            kind = (step_ff < 3'h3) ? TWM_K_TX : TWM_K_STOP;
            tx_byte = (step_ff == 3'h0) ? dev_w : (step_ff == 3'h1) ? addr_ff[7:0] : wdata_ff;
         end
         TWM_OP_RAND_RD: begin
            kind = (step_ff < 3'h2) ? TWM_K_TX : (step_ff == 3'h2) ? TWM_K_RESTART :
                   (step_ff == 3'h3) ? TWM_K_TX : (step_ff == 3'h4) ? TWM_K_RX : TWM_K_STOP;
            tx_byte = (step_ff == 3'h0) ? dev_w : (step_ff == 3'h1) ? addr_ff[7:0] : dev_r;
         end
         TWM_OP_CUR_RD: begin
            kind = (step_ff == 3'h0) ? TWM_K_TX : (step_ff == 3'h1) ? TWM_K_RX : TWM_K_STOP;
            tx_byte = dev_r;
         end
         default: begin
            kind = TWM_K_STOP;
         end
      endcase
   end

   // Sequencer
   always_comb begin
      nxt_st = st_ff;
      nxt_step = step_ff;
      nxt_bit = bit_ff;
      case (st_ff)
         TWM_H_IDLE: begin
            if (cmd_valid) begin
               nxt_st = TWM_H_START;
               nxt_step = 3'h0;
            end
         end
         TWM_H_START: begin
            if (q_end) begin
               nxt_st = TWM_H_DISP;
               nxt_step = (kind == TWM_K_RESTART) ? step_ff + 3'h1 : step_ff;
            end
         end
         TWM_H_DISP: begin
            nxt_bit = 4'h0;
            nxt_st = (kind == TWM_K_STOP) ? TWM_H_STOP :
                     (kind == TWM_K_RESTART) ? TWM_H_START : TWM_H_BIT;
         end
         TWM_H_BIT: begin
            if (q_end & data_bit) begin
               nxt_bit = bit_ff + 4'h1;
            end else if (q_end) begin
               nxt_step = step_ff + 3'h1;
               nxt_st = (kind == TWM_K_TX & sda_s_ff) ? TWM_H_STOP : TWM_H_DISP;
            end
         end
         TWM_H_STOP: begin
            if (q_end) begin
               nxt_st = TWM_H_IDLE;
            end
         end
         default: begin
            nxt_st = TWM_H_IDLE;
         end
      endcase
   end

   // Line levels; bit data moves only in the second low quarter, start and stop edges in the last quarter
   always_comb begin
      nxt_scl = 1'b1;
      nxt_oe = oe_ff;
      case (st_ff)
         TWM_H_START: begin
            nxt_scl = ph_ff[1];
            nxt_oe = (ph_ff == 2'h3);
         end
         TWM_H_BIT: begin
            nxt_scl = ph_ff[1];
            nxt_oe = (ph_ff == 2'h0) ? oe_ff : data_bit & (kind == TWM_K_TX) & ~tx_bit;
         end
         TWM_H_STOP: begin
            nxt_scl = ph_ff[1];
            nxt_oe = (ph_ff == 2'h0) ? oe_ff : (ph_ff != 2'h3);
         end
         TWM_H_DISP: begin
            nxt_scl = scl_ff;
         end
         default: begin
            nxt_oe = 1'b0;
         end
      endcase
   end

   // Control and line registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= TWM_H_IDLE;
         step_ff <= 3'h0;
         bit_ff <= 4'h0;
         qcnt_ff <= 8'h00;
         ph_ff <= 2'h0;
         scl_ff <= 1'b1;
         oe_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         step_ff <= nxt_step;
         bit_ff <= nxt_bit;
         qcnt_ff <= (!timed | tick) ? 8'h00 : qcnt_ff + 8'h01;
         ph_ff <= !timed ? 2'h0 : tick ? ph_ff + 2'h1 : ph_ff;
         scl_ff <= nxt_scl;
         oe_ff <= nxt_oe;
      end
   end

   // Command capture and data path
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         op_ff <= TWM_OP_WRITE;
         addr_ff <= '0;
         wdata_ff <= 8'h00;
         wp_ff <= 1'b0;
         shift_ff <= 8'h00;
         rdata_ff <= 8'h00;
         nack_ff <= 1'b0;
         rsp_valid_ff <= 1'b0;
         sda_meta_ff <= 1'b1;
         sda_s_ff <= 1'b1;
      end else begin
         sda_meta_ff <= bus.sda;
         sda_s_ff <= sda_meta_ff;
         rsp_valid_ff <= q_end & (st_ff == TWM_H_STOP);
         if (accept) begin
            op_ff <= cmd_op;
            addr_ff <= cmd_addr;
            wdata_ff <= cmd_wdata;
            wp_ff <= cmd_wp;
            nack_ff <= 1'b0;
         end
         if (q_end & (st_ff == TWM_H_BIT) & data_bit) begin
            shift_ff <= {shift_ff[6:0], sda_s_ff};
         end
         if (q_end & (st_ff == TWM_H_BIT) & ~data_bit & (kind == TWM_K_RX)) begin
            rdata_ff <= shift_ff;
         end
         if (q_end & (st_ff == TWM_H_BIT) & ~data_bit & (kind == TWM_K_TX) & sda_s_ff) begin
            nack_ff <= 1'b1;
         end
      end
   end

   // Outputs
   assign cmd_ready = (st_ff == TWM_H_IDLE);
   assign rsp_valid = rsp_valid_ff;
   assign rsp_nack = nack_ff;
   assign rsp_rdata = rdata_ff;
   assign bus.scl = scl_ff;
   assign bus.mst_sda_oe = oe_ff;
   assign bus.wp = wp_ff;
endmodule : twm_master

// ### rtl/twm_target.sv
`timescale 1ns/1ps
`include "twm_defs.svh"
module twm_target import twm_pkg::*; #(
   parameter logic [3:0] TYPE_CODE = `TWM_TYPE_CODE,
   parameter int unsigned DEPTH = `TWM_DEPTH
) (
   // Link, clocked by the serial clock
   twm_if.tgt bus,

   // Reset
   input wire logic rstn,

   // Status
   output logic active,
   output logic [`TWM_ADDR_W-1:0] addr_buf
);

   // Edge markers clocked by the data line
   logic start_tg_ff;
   logic stop_tg_ff;

   // Serial clock domain state
   twm_dst_e st_ff, nxt_st;
   logic start_seen_ff;
   logic stop_seen_ff;
   logic wp_meta_ff;
   logic wp_ff;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [6:0] shift_ff, nxt_shift;
   logic [`TWM_HI_W-1:0] hi_ff, nxt_hi;
   logic [`TWM_ADDR_W-1:0] addr_ff, nxt_addr;
   logic fresh_ff, nxt_fresh;
   logic ack_pend_ff, nxt_ack_pend;
   logic [`TWM_DATA_W-1:0] tx_ff, nxt_tx;
   logic mem_we;
   logic oe_ff;

   // Memory ports
   logic [`TWM_ADDR_W-1:0] mem_raddr;
   logic [`TWM_DATA_W-1:0] mem_rdata;

   // Frame conditions seen since the last rising clock
   wire start_hit = start_tg_ff ^ start_seen_ff;
   wire stop_hit = stop_tg_ff ^ stop_seen_ff;

   // Byte assembly
   wire [7:0] byte_in = {shift_ff, bus.sda};
   wire byte_end = (cnt_ff == `TWM_LAST_BIT);
   wire ack_slot = (cnt_ff == `TWM_ACK_SLOT);
   wire type_ok = (byte_in[`TWM_TYPE_MSB:`TWM_TYPE_LSB] == TYPE_CODE);
   wire [`TWM_HI_W-1:0] hi_in = byte_in[`TWM_HI_MSB:`TWM_HI_LSB];

   // Address arithmetic, wrapping at the array end
   wire [`TWM_ADDR_W-1:0] rd_base = {hi_in, addr_ff[7:0]};
   wire [`TWM_ADDR_W-1:0] rd_addr = fresh_ff ? rd_base : rd_base + 11'h001;
   wire [`TWM_ADDR_W-1:0] seq_addr = addr_ff + 11'h001;
   wire [`TWM_ADDR_W-1:0] wr_addr = fresh_ff ? addr_ff : seq_addr;
   wire rd_open = (st_ff == TWM_D_DEV);

   assign mem_raddr = rd_open ? rd_addr : seq_addr;

   // Start: data falls while the clock is high
   always_ff @(negedge bus.sda or negedge rstn) begin
      if (!rstn) begin
         start_tg_ff <= 1'b0;
      end else if (bus.scl) begin
         start_tg_ff <= ~start_tg_ff;
      end
   end

   // Stop: data rises while the clock is high
   always_ff @(posedge bus.sda or negedge rstn) begin
      if (!rstn) begin
         stop_tg_ff <= 1'b0;
      end else if (bus.scl) begin
         stop_tg_ff <= ~stop_tg_ff;
      end
   end

   // Protocol engine, evaluated at each rising clock
   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_shift = shift_ff;
      nxt_hi = hi_ff;
      nxt_addr = addr_ff;
      nxt_fresh = fresh_ff;
      nxt_ack_pend = ack_pend_ff;
      nxt_tx = tx_ff;
      mem_we = 1'b0;
      if (start_hit) begin
         // First address bit arrives with the first rising clock
         nxt_st = TWM_D_DEV;
         nxt_cnt = 4'h1;
         nxt_shift = {6'h00, bus.sda};
         nxt_ack_pend = 1'b0;
      end else if (stop_hit) begin
         nxt_st = TWM_D_IDLE;
         nxt_cnt = 4'h0;
         nxt_ack_pend = 1'b0;
      end else if (st_ff != TWM_D_IDLE) begin
         if (ack_slot) begin
            nxt_cnt = 4'h0;
            nxt_ack_pend = 1'b0;
            if (!ack_pend_ff && st_ff == TWM_D_RD) begin
               if (bus.sda) begin
                  nxt_st = TWM_D_IDLE;
               end else begin
                  nxt_addr = seq_addr;
                  nxt_tx = mem_rdata;
               end
            end
         end else begin
            nxt_cnt = cnt_ff + 4'h1;
            nxt_shift = byte_in[6:0];
            if (byte_end) begin
               case (st_ff)
                  TWM_D_DEV: begin
                     if (!type_ok) begin
                        nxt_st = TWM_D_IDLE;
                     end else begin
                        nxt_hi = hi_in;
                        nxt_ack_pend = 1'b1;
                        if (byte_in[`TWM_RW_BIT]) begin
                           nxt_st = TWM_D_RD;
                           nxt_addr = rd_addr;
                           nxt_fresh = 1'b0;
                           nxt_tx = mem_rdata;
                        end else begin
                           nxt_st = TWM_D_ADDR;
                        end
                     end
                  end
                  TWM_D_ADDR: begin
                     nxt_addr = {hi_ff, byte_in};
                     nxt_fresh = 1'b1;
                     nxt_ack_pend = 1'b1;
                     nxt_st = TWM_D_WR;
                  end
                  TWM_D_WR: begin
                     mem_we = ~wp_ff;
                     nxt_addr = wr_addr;
                     nxt_fresh = 1'b0;
                     nxt_ack_pend = 1'b1;
                  end
                  default: begin
                     nxt_ack_pend = 1'b0;
                  end
               endcase
            end
         end
      end
   end

   // Rising clock: sample and advance
   always_ff @(posedge bus.scl or negedge rstn) begin
      if (!rstn) begin
         st_ff <= TWM_D_IDLE;
         cnt_ff <= 4'h0;
         shift_ff <= 7'h00;
         hi_ff <= 3'h0;
         addr_ff <= 11'h000;
         fresh_ff <= 1'b0;
         ack_pend_ff <= 1'b0;
         tx_ff <= 8'h00;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         shift_ff <= nxt_shift;
         hi_ff <= nxt_hi;
         addr_ff <= nxt_addr;
         fresh_ff <= nxt_fresh;
         ack_pend_ff <= nxt_ack_pend;
         tx_ff <= nxt_tx;
      end
   end

   // Frame marker copies and protect input synchroniser
   always_ff @(posedge bus.scl or negedge rstn) begin
      if (!rstn) begin
         start_seen_ff <= 1'b0;
         stop_seen_ff <= 1'b0;
         wp_meta_ff <= 1'b0;
         wp_ff <= 1'b0;
      end else begin
         start_seen_ff <= start_tg_ff;
         stop_seen_ff <= stop_tg_ff;
         wp_meta_ff <= bus.wp;
         wp_ff <= wp_meta_ff;
      end
   end

   // Drive terms for the next bit slot
   wire drive_ack = ack_pend_ff & ack_slot;
   wire drive_data = (st_ff == TWM_D_RD) & ~cnt_ff[3] & ~tx_ff[~cnt_ff[2:0]];
   wire nxt_oe = (st_ff != TWM_D_IDLE) & (drive_ack | drive_data);

   // Falling clock: change the outgoing bit
   always_ff @(negedge bus.scl or negedge rstn) begin
      if (!rstn) begin
         oe_ff <= 1'b0;
      end else begin
         oe_ff <= nxt_oe;
      end
   end

   // Array of bytes
   twm_mem #(
      .DEPTH(DEPTH),
      .AW(`TWM_ADDR_W),
      .DW(`TWM_DATA_W)
   ) twm_mem_inst (
      .clk(bus.scl),
      .we(mem_we),
      .waddr(wr_addr),
      .wdata(byte_in),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );

   // Pull low only; a pending stop releases at once
   assign bus.tgt_sda_oe = oe_ff & ~stop_hit;

   // Status
   assign active = (st_ff != TWM_D_IDLE) & ~stop_hit;
   assign addr_buf = addr_ff;

endmodule : twm_target

// ### bench/twm_checker.sv
`timescale 1ns/1ps
`include "twm_defs.svh"
module twm_checker #(
   parameter logic [3:0] TYPE_CODE = `TWM_TYPE_CODE
) (
   // System clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Link signals
   input wire logic scl,
   input wire logic mst_sda_oe,
   input wire logic tgt_sda_oe,
   input wire logic wp,
   input wire logic sda
);
   logic scl_ff;
   logic sda_ff;
   logic rd_ff;
   logic first_ff;
   logic in_frame_ff;
   logic [3:0] cnt_ff;
   logic [7:0] sh_ff;

   // Frame markers seen from the system clock
   wire start = scl & scl_ff & sda_ff & ~sda;
   wire stop = scl & scl_ff & ~sda_ff & sda;
   wire rise = scl & ~scl_ff;
   wire ninth = rise & (cnt_ff == 4'h8);
   wire hit = (sh_ff[7:4] == TYPE_CODE);

   // Line history
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scl_ff <= 1'b1;
         sda_ff <= 1'b1;
      end else begin
         scl_ff <= scl;
         sda_ff <= sda;
      end
   end

   // Bit count, first-word flag and direction
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_ff <= 4'h0;
         sh_ff <= 8'h00;
         first_ff <= 1'b1;
         rd_ff <= 1'b0;
         in_frame_ff <= 1'b0;
      end else if (start) begin
         cnt_ff <= 4'h0;
         first_ff <= 1'b1;
         in_frame_ff <= 1'b1;
      end else if (stop) begin
         in_frame_ff <= 1'b0;
      end else if (rise) begin
         sh_ff <= {sh_ff[6:0], sda};
         cnt_ff <= ninth ? 4'h0 : cnt_ff + 4'h1;
         first_ff <= first_ff & ~ninth;
         rd_ff <= (ninth & first_ff) ? sh_ff[0] : rd_ff;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   edge_only_a: assert property ((scl && scl_ff) |-> !$rose(tgt_sda_oe))
      else $error("device data changed while clock high");
   ack_addr_a: assert property ((ninth && first_ff && hit) |-> tgt_sda_oe)
      else $error("matching address word not acknowledged");
   wr_ack_a: assert property ((ninth && !first_ff && !rd_ff) |-> tgt_sda_oe)
      else $error("received byte not acknowledged");
   tx_quiet_a: assert property (
      (rise && !ninth && in_frame_ff && (first_ff || !rd_ff)) |-> !tgt_sda_oe)
      else $error("device drove line while master sends");
   rd_rel_a: assert property ((ninth && !first_ff && rd_ff) |-> !tgt_sda_oe)
      else $error("device held line in master ack slot");
   stop_rel_a: assert property (stop |=> !tgt_sda_oe [*8])
      else $error("device drove line after stop");
   nack_rel_a: assert property ((ninth && sda) |=> !tgt_sda_oe [*8])
      else $error("device drove line after not-acknowledge");
   nack_end_a: assert property ((ninth && sda) |-> ##[1:64] (start || stop))
      else $error("no stop or restart after not-acknowledge");
   wp_hold_a: assert property (in_frame_ff |-> $stable(wp))
      else $error("protect level changed inside frame");
   start_mst_a: assert property (start |-> mst_sda_oe)
      else $error("start not made by master");
   hi_change_a: assert property (
      (scl && scl_ff && $changed(mst_sda_oe)) |-> (start || stop))
      else $error("master data changed while clock high");
endmodule : twm_checker

// ### bench/twm_tb.sv
`timescale 1ns/1ps
`include "twm_defs.svh"
`define CHK(act, exp) begin checks++; if ((act) !== (exp)) begin err_count++; \
   $display("BAD %0t: got %h want %h", $time, act, exp); end end
module twm_tb import twm_pkg::*; ;
   logic clk = 1'b0;
   logic rstn;
   logic cmd_valid = 1'b0;
   logic cmd_valid2 = 1'b0;
   twm_op_e cmd_op = TWM_OP_WRITE;
   logic [10:0] cmd_addr = 11'h000;
   logic [7:0] cmd_wdata = 8'h00;
   logic cmd_wp = 1'b0;
   logic cmd_ready, cmd_ready2, rsp_valid, rsp_valid2, rsp_nack, rsp_nack2;
   logic active, active2;
   logic [7:0] rsp_rdata, rsp_rdata2;
   logic [10:0] addr_buf, addr_buf2;
   int err_count = 0;
   int checks = 0;

   // Main link and a second link whose master sends a foreign type code
   twm_if bus ();
   twm_if bus2 ();

   always #20 clk = ~clk;

   twm_master #(.QTR(2)) twm_master_inst (.bus(bus), .clk(clk), .rstn(rstn),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_wp(cmd_wp), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack),
      .rsp_rdata(rsp_rdata));
   twm_target twm_target_inst (.bus(bus), .rstn(rstn), .active(active), .addr_buf(addr_buf));
   twm_master #(.TYPE_CODE(4'h3), .QTR(2)) twm_master_b_inst (.bus(bus2), .clk(clk),
      .rstn(rstn), .cmd_valid(cmd_valid2), .cmd_ready(cmd_ready2), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wp(cmd_wp), .rsp_valid(rsp_valid2),
      .rsp_nack(rsp_nack2), .rsp_rdata(rsp_rdata2));
   twm_target twm_target_b_inst (.bus(bus2), .rstn(rstn), .active(active2),
      .addr_buf(addr_buf2));
   twm_checker twm_checker_inst (.clk(clk), .rstn(rstn), .scl(bus.scl),
      .mst_sda_oe(bus.mst_sda_oe), .tgt_sda_oe(bus.tgt_sda_oe), .wp(bus.wp), .sda(bus.sda));

   // One command through either master, waits for its completion
   task automatic run(input bit sel, input twm_op_e op, input logic [10:0] a,
      input logic [7:0] d, input logic w, output logic nack, output logic [7:0] rd);
      int n;
      @(posedge clk);
      cmd_op <= op;
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_wp <= w;
      if (sel) cmd_valid2 <= 1'b1;
      else cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_valid2 <= 1'b0;
      n = 0;
      while ((sel ? rsp_valid2 : rsp_valid) !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      `CHK(n < 3000, 1'b1)
      `CHK(sel ? cmd_ready2 : cmd_ready, 1'b1)
      nack = sel ? rsp_nack2 : rsp_nack;
      rd = sel ? rsp_rdata2 : rsp_rdata;
      `CHK(bus.sda, 1'b1)
   endtask : run

   // Write one byte, expect acknowledge throughout
   task automatic wr(input logic [10:0] a, input logic [7:0] d, input logic w);
      logic nk;
      logic [7:0] rd;
      run(1'b0, TWM_OP_WRITE, a, d, w, nk, rd);
      `CHK(nk, 1'b0)
      `CHK(active, 1'b0)
   endtask : wr

   // Read one byte and compare
   task automatic rdchk(input twm_op_e op, input logic [10:0] a, input logic [7:0] exp,
      input logic w);
      logic nk;
      logic [7:0] rd;
      run(1'b0, op, a, 8'h00, w, nk, rd);
      `CHK(nk, 1'b0)
      `CHK(rd, exp)
   endtask : rdchk

   // Write then random read straight after, back to back
   task automatic t_basic;
      wr(11'h123, 8'ha5, 1'b0);
      rdchk(TWM_OP_RAND_RD, 11'h123, 8'ha5, 1'b0);
      `CHK(addr_buf, 11'h123)
      `CHK(active, 1'b0)
   endtask : t_basic

   // Boundary addresses each hold their own byte
   task automatic t_edges;
      logic [10:0] tab [5] = '{11'h000, 11'h0ff, 11'h100, 11'h400, 11'h7ff};
      foreach (tab[i]) wr(tab[i], tab[i][7:0] ^ {5'h00, tab[i][10:8]} ^ 8'h5a, 1'b0);
      foreach (tab[i]) begin
         rdchk(TWM_OP_RAND_RD, tab[i], tab[i][7:0] ^ {5'h00, tab[i][10:8]} ^ 8'h5a,
            1'b0);
      end
   endtask : t_edges

   // Current read joins new upper bits with held lower bits plus one
   task automatic t_current;
      wr(11'h2fe, 8'h3c, 1'b0);
      wr(11'h2ff, 8'h77, 1'b0);
      wr(11'h600, 8'h61, 1'b0);
      rdchk(TWM_OP_RAND_RD, 11'h2fe, 8'h3c, 1'b0);
      rdchk(TWM_OP_CUR_RD, 11'h255, 8'h77, 1'b0);
      rdchk(TWM_OP_CUR_RD, 11'h500, 8'h61, 1'b0);
      `CHK(addr_buf, 11'h600)
      rdchk(TWM_OP_RAND_RD, 11'h7ff, 8'hff ^ 8'h07 ^ 8'h5a, 1'b0);
      rdchk(TWM_OP_CUR_RD, 11'h700, 8'h5a, 1'b0);
      `CHK(addr_buf, 11'h000)
   endtask : t_current

   // Protected write is acknowledged but leaves memory alone
   task automatic t_protect;
      wr(11'h050, 8'h11, 1'b0);
      wr(11'h050, 8'h22, 1'b1);
      rdchk(TWM_OP_RAND_RD, 11'h050, 8'h11, 1'b1);
      wr(11'h050, 8'h33, 1'b0);
      rdchk(TWM_OP_RAND_RD, 11'h050, 8'h33, 1'b0);
   endtask : t_protect

   // Foreign type code gets no acknowledge and no state change
   task automatic t_mismatch;
      logic nk;
      logic [7:0] rd;
      run(1'b1, TWM_OP_WRITE, 11'h0aa, 8'h99, 1'b0, nk, rd);
      `CHK(nk, 1'b1)
      `CHK(active2, 1'b0)
      `CHK(addr_buf2, 11'h000)
      `CHK(bus2.sda, 1'b1)
   endtask : t_mismatch

   // Verdict and end of run
   task automatic wrap_up;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : wrap_up

   // Main sequence
   initial begin
      rstn <= 1'b0; // Edge at time zero fires every async reset
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_basic();
      t_edges();
      t_current();
      t_protect();
      t_mismatch();
      wrap_up();
   end

   // Watchdog
   initial begin
      #(40 * 60000);
      err_count++;
      $display("BAD %0t: timeout", $time);
      wrap_up();
   end
endmodule : twm_tb
